// ---- common/reset_cause_pkg.sv ----
// package: register map, flag positions and carrier types for reset cause
package reset_cause_pkg;
	localparam logic [11:0] reset_cause_record_off = 12'h004;
	localparam logic [11:0] periph_reset_ctl_one_off = 12'h008;
	localparam logic [31:0] periph_reset_ctl_one_rst = 32'h0000_0000;
	localparam int cpu_only_reset_bit = 1;
	localparam int power_on_reset_flag_pos = 0;
	localparam int pin_reset_flag_pos = 1;
	localparam int watchdog_reset_flag_pos = 2;
	localparam int low_voltage_reset_flag_pos = 3;
	localparam int brownout_reset_flag_pos = 4;
	localparam int core_request_reset_flag_pos = 5;
	localparam int cpu_only_reset_flag_pos = 7;
	localparam logic [7:0] flag_mask = 8'hbf;
	localparam logic [7:0] flag_rst = 8'h00;
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [2:0] hsize_word = 3'h2;
	localparam int sync_stages = 3;

	// raw reset-source event inputs
	typedef struct packed {
		logic core_system_reset_request;
		logic brownout_detector;
		logic low_voltage_reset_controller;
		logic watchdog_timer;
		logic window_watchdog_timer;
		logic external_reset_pin_n;
		logic power_on;
	} reset_sources_t;

	typedef enum logic [1:0] {
		bus_idle = 2'b00,
		bus_write = 2'b01,
		bus_read = 2'b11
	} bus_state_t;
endpackage : reset_cause_pkg

// ---- verilog/pin_sync.sv ----
// three-stage synchroniser with agreement filter for one input
`timescale 1ns/100ps
module pin_sync #(
	parameter logic reset_level = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pin_in,
	output logic level
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic level_q;
	logic level_d;

	always_comb begin
		stage_d = {stage_q[1:0], pin_in};
		level_d = level_q;
		if (stage_q[2] == stage_q[1]) begin
			level_d = stage_q[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage_q <= {3{reset_level}};
			level_q <= reset_level;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule : pin_sync

// ---- verilog/reset_cause_record.sv ----
// reset cause record: sticky write-1-clear reset source flags on ahb-lite
//
// Notes on behaviour
// - a 32-bit cause register holds flags in bits 7:0, bits 31:8 and 6 read zero.
// - writing 1 to bit 1 of the peripheral reset control one register sets bit 7.
// - a cpu-only reset pulses the core and flash controller reset and sets bit 7.
// - a core system reset request sets bit 5.
// - a brown-out detector reset sets bit 4, else bit 4 stays 0.
// - a low-voltage reset controller reset sets bit 3.
// - each flag clears only on hresetn or when software writes 1 to it; 0 leaves it.
// - a watchdog or window watchdog reset sets bit 2.
// - a reset from the external active-low pin sets bit 1.
// - bit 3 reads 0 without a low-voltage reset and clears on a write of 1.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
module reset_cause_record (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire reset_cause_pkg::reset_sources_t sources,
	output logic cpu_flash_reset
);
	localparam int nsrc = 7;

	reset_cause_pkg::bus_state_t state_q;
	reset_cause_pkg::bus_state_t state_d;
	logic [11:0] addr_q;
	logic [11:0] addr_d;
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [31:0] ctl_q;
	logic [31:0] ctl_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic cpu_rst_q;
	logic cpu_rst_d;
	logic [nsrc-1:0] lvl;
	logic [nsrc-1:0] lvl_q;
	logic [nsrc-1:0] rise;
	logic [nsrc-1:0] raw;
	logic [7:0] set_v;
	logic [7:0] clr_v;
	logic take;
	logic [nsrc-1:0] lvl_d;
	logic wr_cause;
	logic wr_ctl;

	// address decode shared by read and write paths
	function automatic logic is_cause(input logic [11:0] a);
		return a == reset_cause_pkg::reset_cause_record_off;
	endfunction : is_cause

	function automatic logic is_ctl(input logic [11:0] a);
		return a == reset_cause_pkg::periph_reset_ctl_one_off;
	endfunction : is_ctl

	function automatic logic [31:0] read_mux(input logic [11:0] a,
		input logic [7:0] f, input logic [31:0] c);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (is_cause(a)) begin
			r = {24'h00_0000, f & reset_cause_pkg::flag_mask};
		end else if (is_ctl(a)) begin
			r = c;
		end
		return r;
	endfunction : read_mux

	// source edges onto flag positions
	function automatic logic [7:0] edge_flags(input logic [nsrc-1:0] e);
		logic [7:0] s;
		s = 8'h00;
		s[reset_cause_pkg::core_request_reset_flag_pos] = e[6];
		s[reset_cause_pkg::brownout_reset_flag_pos] = e[5];
		s[reset_cause_pkg::low_voltage_reset_flag_pos] = e[4];
		s[reset_cause_pkg::watchdog_reset_flag_pos] = e[3] | e[2];
		s[reset_cause_pkg::pin_reset_flag_pos] = e[1];
		s[reset_cause_pkg::power_on_reset_flag_pos] = e[0];
		return s;
	endfunction : edge_flags

	// pin is active low: a low level is the reset event
	assign raw = {sources.core_system_reset_request,
		sources.brownout_detector, sources.low_voltage_reset_controller,
		sources.watchdog_timer, sources.window_watchdog_timer,
		~sources.external_reset_pin_n, sources.power_on};

	for (genvar i = 0; i < nsrc; i++) begin : g_sync
		pin_sync #(.reset_level(1'b0)) u_sync (
			.hclk(hclk),
			.hresetn(hresetn),
			.pin_in(raw[i]),
			.level(lvl[i])
		);
	end

	assign take = hsel && hready && htrans[1];

	// edge detect on the synchronised source levels
	always_comb begin
		lvl_d = lvl;
		rise = lvl & ~lvl_q;
	end

	// write decode from the registered address phase
	always_comb begin
		wr_cause = 1'b0;
		wr_ctl = 1'b0;
		unique case (state_q)
			reset_cause_pkg::bus_write: begin
				wr_cause = is_cause(addr_q);
				wr_ctl = is_ctl(addr_q);
			end
			reset_cause_pkg::bus_read: begin
				wr_cause = 1'b0;
				wr_ctl = 1'b0;
			end
			reset_cause_pkg::bus_idle: begin
				wr_cause = 1'b0;
				wr_ctl = 1'b0;
			end
			default: begin
				wr_cause = 1'b0;
				wr_ctl = 1'b0;
			end
		endcase
	end

	// flag group: source edges set, software write-1 clears
	always_comb begin
		set_v = edge_flags(rise);
		set_v[reset_cause_pkg::cpu_only_reset_flag_pos] = cpu_rst_q;
		clr_v = 8'h00;
		if (wr_cause) begin
			clr_v = hwdata[7:0];
		end
		// set wins over a clear in the same cycle
		flags_d = (flags_q & ~clr_v) | set_v;
		flags_d = flags_d & reset_cause_pkg::flag_mask;
	end

	// control group: cpu-only bit self-clears into a one-cycle pulse
	always_comb begin
		ctl_d = ctl_q;
		cpu_rst_d = 1'b0;
		if (wr_ctl) begin
			ctl_d = hwdata;
			ctl_d[reset_cause_pkg::cpu_only_reset_bit] = 1'b0;
			cpu_rst_d = hwdata[reset_cause_pkg::cpu_only_reset_bit];
		end
	end

	// bus group: address phase capture and registered read data
	always_comb begin
		state_d = reset_cause_pkg::bus_idle;
		addr_d = addr_q;
		rdata_d = rdata_q;
		if (take) begin
			addr_d = haddr;
			state_d = hwrite ? reset_cause_pkg::bus_write : reset_cause_pkg::bus_read;
			if (!hwrite) begin
				rdata_d = read_mux(haddr, flags_q, ctl_q);
			end
		end
	end

	// bus group registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= reset_cause_pkg::bus_idle;
			addr_q <= 12'h000;
			rdata_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
		end
	end

	// flag group registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= reset_cause_pkg::flag_rst;
		end else begin
			flags_q <= flags_d;
		end
	end

	// control group registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_q <= reset_cause_pkg::periph_reset_ctl_one_rst;
			cpu_rst_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			cpu_rst_q <= cpu_rst_d;
		end
	end

	// edge detect registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lvl_q <= '0;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign cpu_flash_reset = cpu_rst_q;
endmodule : reset_cause_record

// ---- testbench/reset_cause_record_assertions.sv ----
// checker: bus read and cpu reset pulse properties of reset cause record
`timescale 1ns/100ps
module reset_cause_record_assertions (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire reset_cause_pkg::reset_sources_t sources,
	input wire logic cpu_flash_reset
);
	logic rd4_q, rdx_q, wr8_q, bod_q, lvr_q, cpu_q, cpu2_q;
	wire logic tk = hsel & hready & htrans[1] & !hwrite;
	wire logic a4 = haddr == reset_cause_pkg::reset_cause_record_off;
	wire logic a8 = haddr == reset_cause_pkg::periph_reset_ctl_one_off;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{rd4_q, rdx_q, wr8_q, bod_q, lvr_q, cpu_q, cpu2_q} <= 7'h00;
		end else begin
			rd4_q <= tk & a4;
			rdx_q <= tk & !a4 & !a8;
			wr8_q <= hsel & hready & htrans[1] & hwrite & a8;
			bod_q <= bod_q | sources.brownout_detector;
			lvr_q <= lvr_q | sources.low_voltage_reset_controller;
			cpu_q <= wr8_q & hwdata[1];
			cpu2_q <= cpu_q;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_rdy; hreadyout; endproperty
	a_rdy: assert property (p_rdy) else $error("wait state seen");
	property p_rsv; rd4_q |-> hrdata[31:8] == 24'h0 && !hrdata[6]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_unm; rdx_q |-> hrdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped data");
	property p_bod; rd4_q && !bod_q |-> !hrdata[4]; endproperty
	a_bod: assert property (p_bod) else $error("brownout flag");
	property p_lvr; rd4_q && !lvr_q |-> !hrdata[3]; endproperty
	a_lvr: assert property (p_lvr) else $error("low voltage flag");
	property p_cpu; cpu_q |-> ##[0:1] cpu_flash_reset; endproperty
	a_cpu: assert property (p_cpu) else $error("no cpu reset");
	property p_pls; cpu_flash_reset |=> !cpu_flash_reset; endproperty
	a_pls: assert property (p_pls) else $error("long pulse");
	property p_why; cpu_flash_reset |-> cpu_q || cpu2_q; endproperty
	a_why: assert property (p_why) else $error("stray pulse");
endmodule : reset_cause_record_assertions
bind reset_cause_record reset_cause_record_assertions u_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .sources(sources),
	.cpu_flash_reset(cpu_flash_reset));

// ---- testbench/reset_cause_record_tb_top.sv ----
// testbench: register tests of reset cause record over ahb-lite
`timescale 1ns/100ps
module reset_cause_record_tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [11:0] a4 = reset_cause_pkg::reset_cause_record_off;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0, hrdata, r;
	logic hreadyout, hresp, cpu_flash_reset;
	reset_cause_pkg::reset_sources_t src = 7'h02;
	int n_errors = 0, checked = 0;
	int pulses = 0;
	logic hresp_seen = 1'b0;
	logic [7:0] fl [7] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h10, 8'h20};
	reset_cause_record u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sources(src),
		.cpu_flash_reset(cpu_flash_reset));
	initial forever #10 hclk = ~hclk;
	always @(posedge hclk) begin
		if (cpu_flash_reset === 1'b1) pulses <= pulses + 1;
		if (hresp !== 1'b0) hresp_seen <= 1'b1;
	end
	task complete_run;
		if (n_errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	task wait_rdy;
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) break;
		end
		if (i == 20) begin
			n_errors++;
			complete_run;
		end
	endtask : wait_rdy
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		{hsel, haddr, htrans, hwrite, hsize} <= {1'b1, a,
			reset_cause_pkg::htrans_nonseq, w, reset_cause_pkg::hsize_word};
		wait_rdy;
		{hsel, htrans} <= 3'h0;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	endtask : xfer
	task chk(input logic [31:0] e);
		checked++;
		if (r !== e) begin
			$display("Error at %0t: got %h exp %h", $time, r, e);
			n_errors++;
		end
	endtask : chk
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
		xfer(1'b0, a4, 32'h0);
		chk(32'h0);
		for (int i = 0; i < 7; i++) begin
			src <= src ^ (7'h01 << i);
			repeat (8) @(posedge hclk);
			src <= 7'h02;
			xfer(1'b0, a4, 32'h0);
			chk({24'h0, fl[i]});
			xfer(1'b1, a4, ~{24'h0, fl[i]});
			xfer(1'b0, a4, 32'h0);
			chk({24'h0, fl[i]});
			xfer(1'b1, a4, {24'h0, fl[i]});
			xfer(1'b0, a4, 32'h0);
			chk(32'h0);
		end
		r = pulses;
		chk(32'h0);
		xfer(1'b1, reset_cause_pkg::periph_reset_ctl_one_off, 32'h7);
		xfer(1'b0, reset_cause_pkg::periph_reset_ctl_one_off, 32'h0);
		chk(32'h5);
		xfer(1'b0, a4, 32'h0);
		chk(32'h80);
		r = pulses;
		chk(32'h1);
		xfer(1'b1, 12'h00c, 32'hffff_ffff);
		xfer(1'b0, 12'h00c, 32'h0);
		chk(32'h0);
		r = {31'h0, hresp_seen};
		chk(32'h0);
		complete_run;
	end
	initial begin
		repeat (5000) @(posedge hclk);
		n_errors++;
		complete_run;
	end
endmodule : reset_cause_record_tb_top
